// ### hdl/tmwm_core_if.sv
// Signals between the register block, counter unit and waveform unit.
// Assumes all three sit on ref_clk.
interface tmwm_core_if import tmwm_pkg::*; #(parameter int W = 8);
  logic tick; // Timer clock enable
  tmwm_mode_t mode; // Waveform mode select
  logic count_wr; // Software counter write
  logic [W-1:0] count_wdata; // Counter write data
  logic [W-1:0] cmp_active; // Compare value in use
  logic [W-1:0] count; // Counter value
  logic match_ev; // Unblocked compare match on a tick
  logic wrap_ev; // Tick with counter at max
  logic max_ev; // Fast PWM tick that brings counter to max
  modport regs (output tick, mode, count_wr, count_wdata, cmp_active,
    input count, match_ev, wrap_ev, max_ev);
  modport cnt (input tick, mode, count_wr, count_wdata, cmp_active,
    output count, match_ev, wrap_ev, max_ev);
  modport wav (input mode, match_ev, wrap_ev);
endinterface : tmwm_core_if

// ### hdl/tmwm_counter.sv
// Counter unit: count sequence, match detect and match blocking.
// Assumes tick is a one-cycle enable from logic on ref_clk.
`include "tmwm_params.svh"
module tmwm_counter import tmwm_pkg::*; #(parameter int W = 8) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Core signals
  tmwm_core_if.cnt core
);
  logic [W-1:0] count_ff; // Counter value
  logic block_ff; // Match blocked until next tick
  logic eq; // Counter equals compare value
  assign eq = (core.count == core.cmp_active);
  assign core.count = count_ff;
  // A write blocks the match of the following tick
  assign core.match_ev = core.tick && eq && !block_ff;
  assign core.wrap_ev = core.tick && (count_ff == `TMWM_CNT_MAX);
  assign core.max_ev = core.tick && (core.mode == TMWM_MODE_FAST) &&
    (count_ff == (`TMWM_CNT_MAX - 8'h01));
  // Count sequence; software write wins over counting
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      count_ff <= `TMWM_RST_BYTE;
    else if (core.count_wr)
      count_ff <= core.count_wdata;
    else if (core.tick && (core.mode == TMWM_MODE_CLEAR) && core.match_ev)
      count_ff <= `TMWM_CNT_BOTTOM;
    else if (core.tick)
      count_ff <= count_ff + 8'h01;
  end
  // Block flag: set by a write, dropped on the next tick
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      block_ff <= 1'b0;
    else if (core.count_wr)
      block_ff <= 1'b1;
    else if (core.tick)
      block_ff <= 1'b0;
  end
endmodule : tmwm_counter

// ### hdl/tmwm_params.svh
// Constants for the 8-bit timer with compare output unit.
// Assumes one 50 MHz clock and a timer tick supplied by an outside prescaler.
// Summary of operation
// - Nonzero action field: pin takes compare output state
// - Pin driven only when direction bit selects output
// - Port override ignores the waveform mode
// - Output state settable before pin is enabled
// - Action zero leaves output state untouched
// - New action used at next match; force applies now
// - Only mode select steers counting
// - Mode 0 counts up, wraps 0xFF to 0x00
// - Normal mode overflow flag set as counter hits zero
// - Normal mode counter writable at any time
// - Mode 2 clears counter on compare match
// - Clear-on-match compare value unbuffered, may wrap
// - Clear-on-match action 1 toggles on match
// - Clear-on-match overflow set stepping max to zero
// - Mode 3 counts zero to max, then restarts
// - Fast PWM: 2 clears on match, sets at bottom
// - Fast PWM overflow flag set reaching max
// - Fast PWM period is 256 timer ticks
// - Compare zero spikes; compare max gives steady level
// - Fast PWM action 1 toggles, buffered compare
// - Compare double buffered in PWM, direct otherwise
// - Match sets flag next cycle; write one clears
// - Force strobe updates output outside PWM modes, no flag, no clear
// - Counter write blocks match in next tick
`ifndef TMWM_PARAMS_SVH
`define TMWM_PARAMS_SVH
// Register byte offsets
`define TMWM_OFS_CTRL 5'h00
`define TMWM_OFS_COUNT 5'h04
`define TMWM_OFS_COMPARE 5'h08
`define TMWM_OFS_FLAGS 5'h0C
`define TMWM_OFS_OUTSTATE 5'h10
// Control field positions
`define TMWM_CTRL_MODE_LSB 0
`define TMWM_CTRL_ACT_LSB 4
`define TMWM_CTRL_FORCE_BIT 7
// Flag bit positions
`define TMWM_FLAG_OVF_BIT 0
`define TMWM_FLAG_CMF_BIT 1
// Reset values and count extremes
`define TMWM_RST_BYTE 8'h00
`define TMWM_CNT_MAX 8'hFF
`define TMWM_CNT_BOTTOM 8'h00
`endif

// ### hdl/tmwm_pkg.sv
// Types shared by the timer modules.
// Assumes nothing beyond a SystemVerilog compiler.
package tmwm_pkg;
  // Waveform mode select encodings
  typedef enum logic [1:0] {
    TMWM_MODE_NORMAL = 2'b00,
    TMWM_MODE_PHASE = 2'b01,
    TMWM_MODE_CLEAR = 2'b10,
    TMWM_MODE_FAST = 2'b11
  } tmwm_mode_t;
  // Bus slave states
  typedef enum logic [0:0] {
    TMWM_BUS_IDLE = 1'b0,
    TMWM_BUS_ANSWER = 1'b1
  } tmwm_bus_t;
  // True for the PWM modes, which buffer the compare value
  function automatic logic tmwm_is_pwm(input tmwm_mode_t mode);
    tmwm_is_pwm = (mode == TMWM_MODE_FAST) || (mode == TMWM_MODE_PHASE);
  endfunction : tmwm_is_pwm
endpackage : tmwm_pkg

// ### hdl/tmwm_timer.sv
// Top of the 8-bit timer: Avalon-MM register slave, compare buffering,
// flags, and the counter and waveform units.
// Assumes tick, port_value and pin_direction_bit come from ref_clk logic.
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
`include "tmwm_params.svh"
module tmwm_timer import tmwm_pkg::*; #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Timer clock enable from prescaler
  input wire logic timer_tick,
  // Port pin side
  input wire logic port_value,
  input wire logic pin_direction_bit,
  output logic pin_out,
  output logic pin_oe_b
);

  // Bus slave state
  tmwm_bus_t bus_ff;
  tmwm_bus_t nxt_bus;
  logic [31:0] rdata_ff; // Read data held for the answer cycle
  logic [31:0] nxt_rdata; // Read data decoded from address
  logic wr_go; // Write committed this cycle
  logic lane0; // Low byte lane enabled

  // Software visible state
  tmwm_mode_t mode_ff; // Waveform mode select
  logic [1:0] action_ff; // Compare output action
  logic [W-1:0] cmp_buf_ff; // Compare value as written
  logic [W-1:0] cmp_act_ff; // Compare value in use
  logic ovf_ff; // Overflow flag
  logic cmf_ff; // Compare match flag

  // Decoded write strobes
  logic wr_ctrl;
  logic wr_count;
  logic wr_cmp;
  logic wr_flags;
  logic wr_state;
  logic force_ev; // Force compare strobe
  logic ovf_ev; // Overflow event for the current mode
  logic oc_state; // Compare output state

  // Core bundle
  tmwm_core_if #(.W(W)) core();

  // Address decode for the write strobes; the read mux decodes on its own
  function automatic logic hit_ofs(input logic [4:0] addr, input logic [4:0] ofs);
    hit_ofs = (addr == ofs);
  endfunction : hit_ofs

  // One wait cycle on every access; the answer cycle is when it commits.
  // The fixed latency keeps the slave simple and lets reads be registered.
  assign avs_waitrequest = (avs_read || avs_write) && (bus_ff == TMWM_BUS_IDLE);
  assign avs_readdata = rdata_ff;
  assign lane0 = avs_byteenable[0];
  assign wr_go = avs_write && (bus_ff == TMWM_BUS_ANSWER) && lane0;

  // Write strobes per register
  assign wr_ctrl = wr_go && hit_ofs(avs_address, `TMWM_OFS_CTRL);
  assign wr_count = wr_go && hit_ofs(avs_address, `TMWM_OFS_COUNT);
  assign wr_cmp = wr_go && hit_ofs(avs_address, `TMWM_OFS_COMPARE);
  assign wr_flags = wr_go && hit_ofs(avs_address, `TMWM_OFS_FLAGS);
  assign wr_state = wr_go && hit_ofs(avs_address, `TMWM_OFS_OUTSTATE);
  assign force_ev = wr_ctrl && avs_writedata[`TMWM_CTRL_FORCE_BIT];

  // Bus sequencing
  always_comb
  begin
    nxt_bus = bus_ff;
    case (bus_ff)
      TMWM_BUS_IDLE:
      begin
        // Request seen: answer next cycle
        if (avs_read || avs_write)
          nxt_bus = TMWM_BUS_ANSWER;
      end
      TMWM_BUS_ANSWER:
      begin
        // Master releases after the answer edge
        nxt_bus = TMWM_BUS_IDLE;
      end
      default:
        nxt_bus = TMWM_BUS_IDLE;
    endcase
  end

  // Bus state register
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      bus_ff <= TMWM_BUS_IDLE;
    else
      bus_ff <= nxt_bus;
  end

  // Read mux; unmapped offsets and upper bits read zero
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    case (avs_address)
      `TMWM_OFS_CTRL:
      begin
        // Force strobe reads back as zero
        nxt_rdata[`TMWM_CTRL_MODE_LSB +: 2] = mode_ff;
        nxt_rdata[`TMWM_CTRL_ACT_LSB +: 2] = action_ff;
      end
      `TMWM_OFS_COUNT:
        nxt_rdata[W-1:0] = core.count;
      `TMWM_OFS_COMPARE:
        nxt_rdata[W-1:0] = cmp_buf_ff; // Buffer side in PWM modes
      `TMWM_OFS_FLAGS:
      begin
        nxt_rdata[`TMWM_FLAG_OVF_BIT] = ovf_ff;
        nxt_rdata[`TMWM_FLAG_CMF_BIT] = cmf_ff;
      end
      `TMWM_OFS_OUTSTATE:
        nxt_rdata[0] = oc_state;
      default:
        nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle, stands through the answer
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      rdata_ff <= 32'h0000_0000;
    else if (avs_read && (bus_ff == TMWM_BUS_IDLE))
      rdata_ff <= nxt_rdata;
  end

  // Control register: mode and action
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      mode_ff <= TMWM_MODE_NORMAL;
      action_ff <= 2'b00;
    end
    else if (wr_ctrl)
    begin
      mode_ff <= tmwm_mode_t'(avs_writedata[`TMWM_CTRL_MODE_LSB +: 2]);
      action_ff <= avs_writedata[`TMWM_CTRL_ACT_LSB +: 2];
    end
  end

  // Compare value: direct outside PWM, loaded at restart in PWM
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      cmp_buf_ff <= `TMWM_RST_BYTE;
      cmp_act_ff <= `TMWM_RST_BYTE;
    end
    else
    begin
      if (wr_cmp)
        cmp_buf_ff <= avs_writedata[W-1:0];
      if (wr_cmp && !tmwm_is_pwm(mode_ff))
        cmp_act_ff <= avs_writedata[W-1:0];
      else if (tmwm_is_pwm(mode_ff) && core.wrap_ev)
        cmp_act_ff <= cmp_buf_ff;
    end
  end

  // Overflow event chosen by mode
  always_comb
  begin
    if (mode_ff == TMWM_MODE_FAST)
      ovf_ev = core.max_ev;
    else
      ovf_ev = core.wrap_ev;
  end

  // Overflow flag: hardware only sets; write one clears, set wins
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      ovf_ff <= 1'b0;
    else if (ovf_ev)
      ovf_ff <= 1'b1;
    else if (wr_flags && avs_writedata[`TMWM_FLAG_OVF_BIT])
      ovf_ff <= 1'b0;
  end

  // Match flag: set on the match tick, not by force; set wins
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      cmf_ff <= 1'b0;
    else if (core.match_ev)
      cmf_ff <= 1'b1;
    else if (wr_flags && avs_writedata[`TMWM_FLAG_CMF_BIT])
      cmf_ff <= 1'b0;
  end

  // Core drive
  assign core.tick = timer_tick;
  assign core.mode = mode_ff; // Only mode steers counting
  assign core.count_wr = wr_count;
  assign core.count_wdata = avs_writedata[W-1:0];
  assign core.cmp_active = cmp_act_ff;

  // Counter unit
  tmwm_counter #(.W(W)) u_counter (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .core(core)
  );

  // Waveform unit
  tmwm_wavegen u_wavegen (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .core(core),
    .action(action_ff),
    .force_ev(force_ev),
    .state_wr(wr_state),
    .state_wdata(avs_writedata[0]),
    .oc_state(oc_state),
    .port_value(port_value),
    .pin_direction_bit(pin_direction_bit),
    .pin_out(pin_out),
    .pin_oe_b(pin_oe_b)
  );

  // Checks, all on ref_clk
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  // Override follows action, not mode
  chk_pin_override: assert property (
    (action_ff != 2'b00) |=> (pin_out == $past(oc_state)))
    else $error("pin does not follow compare output state");

  // Drive only with direction bit set
  chk_pin_drive: assert property (
    1'b1 |=> (pin_oe_b == !$past(pin_direction_bit)))
    else $error("pin enable does not follow direction bit");

  // Action zero holds the state across matches
  chk_action_zero: assert property (
    (action_ff == 2'b00 && !wr_state && !force_ev) |=> (oc_state == $past(oc_state)))
    else $error("output state moved with action zero");

  // Normal mode wrap
  chk_normal_wrap: assert property (
    (mode_ff == TMWM_MODE_NORMAL && core.wrap_ev && !wr_count) |=>
      (core.count == `TMWM_CNT_BOTTOM) && ovf_ff)
    else $error("normal mode wrap or overflow wrong");

  // Clear on match
  chk_clear_match: assert property (
    (mode_ff == TMWM_MODE_CLEAR && core.match_ev && !wr_count) |=>
      (core.count == `TMWM_CNT_BOTTOM))
    else $error("counter not cleared on match");

  // Toggle on match in clear-on-match mode
  chk_match_toggle: assert property (
    (mode_ff == TMWM_MODE_CLEAR && action_ff == 2'b01 && core.match_ev && !wr_state) |=>
      (oc_state != $past(oc_state)))
    else $error("output did not toggle on match");

  // Match flag rises one cycle after the match tick
  chk_match_flag: assert property (
    core.match_ev |=> cmf_ff)
    else $error("match flag not set");

  // Counter write blocks the next tick's match
  chk_write_block: assert property (
    (wr_count ##1 (timer_tick && !wr_count)) |-> !core.match_ev)
    else $error("match not blocked after counter write");

  // Force never raises the match flag
  chk_force_noflag: assert property (
    (force_ev && !core.match_ev && !cmf_ff) |=> !cmf_ff)
    else $error("force set the match flag");

  // Fast PWM non-inverting set at restart
  chk_pwm_bottom: assert property (
    (mode_ff == TMWM_MODE_FAST && action_ff == 2'b10 && core.wrap_ev && !wr_state) |=>
      oc_state)
    else $error("fast PWM output not set at bottom");

  // Fast PWM overflow on reaching max
  chk_fast_max: assert property (
    (mode_ff == TMWM_MODE_FAST && core.max_ev && !wr_count) |=>
      ovf_ff && (core.count == `TMWM_CNT_MAX))
    else $error("fast PWM overflow not set at max");

  // Block holds through one idle cycle up to the first tick after the write
  chk_block_gap: assert property (
    (wr_count ##1 (!timer_tick && !wr_count) ##1 (timer_tick && !wr_count)) |->
      !core.match_ev)
    else $error("match not blocked at first tick after counter write");

  // Overflow in clear-on-match mode as the counter leaves max
  chk_clear_ovf: assert property (
    (mode_ff == TMWM_MODE_CLEAR && core.wrap_ev) |=> ovf_ff)
    else $error("clear-on-match overflow not set");

  // PWM compare value loads from the buffer at the restart tick
  chk_pwm_load: assert property (
    (tmwm_is_pwm(mode_ff) && core.wrap_ev) |=> (cmp_act_ff == $past(cmp_buf_ff)))
    else $error("buffered compare value not loaded at restart");

  // Fast PWM inverting clears at restart
  chk_pwm_inv: assert property (
    (mode_ff == TMWM_MODE_FAST && action_ff == 2'b11 && core.wrap_ev && !wr_state) |=>
      !oc_state)
    else $error("inverted fast PWM output not cleared at bottom");

  // Fast PWM action 1 toggles on match
  chk_pwm_toggle: assert property (
    (mode_ff == TMWM_MODE_FAST && action_ff == 2'b01 && core.match_ev && !wr_state) |=>
      (oc_state != $past(oc_state)))
    else $error("fast PWM output did not toggle on match");

  // Bus answers after exactly one wait cycle
  chk_bus_answer: assert property (
    avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

endmodule : tmwm_timer

// ### hdl/tmwm_wavegen.sv
// Waveform unit: compare output state and port pin override.
// Assumes the port value and direction bit are on ref_clk.
module tmwm_wavegen import tmwm_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Core signals
  tmwm_core_if.wav core,
  // Software controls
  input wire logic [1:0] action,
  input wire logic force_ev,
  input wire logic state_wr,
  input wire logic state_wdata,
  output logic oc_state,
  // Port pin
  input wire logic port_value,
  input wire logic pin_direction_bit,
  output logic pin_out,
  output logic pin_oe_b
);
  logic oc_ff; // Compare output state
  logic hit; // Match or force in effect
  assign oc_state = oc_ff;
  // Force only counts outside PWM modes
  assign hit = core.match_ev || (force_ev && !tmwm_is_pwm(core.mode));
  // Output state; action read live, so a change acts on the next match
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      oc_ff <= 1'b0;
    else if (state_wr)
      oc_ff <= state_wdata;
    else if (core.mode == TMWM_MODE_FAST && action[1] && core.wrap_ev)
      oc_ff <= !action[0]; // Bottom wins so compare max is steady
    else if (hit)
      case (action)
        2'b00: oc_ff <= oc_ff;
        2'b01: oc_ff <= !oc_ff;
        2'b10: oc_ff <= 1'b0;
        2'b11: oc_ff <= 1'b1;
        default: oc_ff <= oc_ff;
      endcase
  end
  // Pin mux, mode independent; direction bit alone enables drive
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      pin_out <= 1'b0;
      pin_oe_b <= 1'b1;
    end
    else
    begin
      pin_out <= (action != 2'b00) ? oc_ff : port_value;
      pin_oe_b <= !pin_direction_bit;
    end
  end
endmodule : tmwm_wavegen

// ### verif/tb_timer_waveform_modes.sv
// Self-checking bench for the timer: register access, counting and pin.
// Assumes the timer top, its package and the port pin model.
`include "tmwm_params.svh"
module tb_timer_waveform_modes import tmwm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench signals
  logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic timer_tick, port_value, pin_direction_bit, pin_out, pin_oe_b;
  logic pin_level, want_value, want_dir;
  logic [7:0] q;
  int miscompares, comparisons;
  // Force table: start state and expected state for actions 1 to 3
  logic [2:0] f_init = 3'b011;
  logic [2:0] f_exp = 3'b100;
  tmwm_timer #(.W(8)) uut (.ref_clk(ref_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timer_tick(timer_tick), .port_value(port_value),
    .pin_direction_bit(pin_direction_bit), .pin_out(pin_out), .pin_oe_b(pin_oe_b));
  tmwm_port_model pm (.ref_clk(ref_clk), .rst_b(rst_b), .want_value(want_value),
    .want_dir(want_dir), .port_value(port_value),
    .pin_direction_bit(pin_direction_bit), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
    .pin_level(pin_level));
  // 50 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Verdict and end of run
  task test_done;
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // Compare one value
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One Avalon access; the request stands until the rising edge that samples
  // waitrequest low, and read data is taken at that same edge
  task bus(input logic w, input logic [4:0] a, input logic [7:0] d,
    input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 20)
    begin
      check("waitrequest", 32'h0000_0001, 32'h0000_0000);
      test_done();
    end
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // One idle cycle before the next request
    @(posedge ref_clk);
  endtask : bus
  // Write one register
  task wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr
  // Read one register and compare
  task rdc(input string what, input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    check(what, q, e);
  endtask : rdc
  // Give n timer ticks, then one quiet cycle for the flags to land
  task ticks(input int n);
    repeat (n)
    begin
      timer_tick <= 1'b1;
      @(posedge ref_clk);
    end
    timer_tick <= 1'b0;
    @(posedge ref_clk);
  endtask : ticks
  // Set port level and direction; three edges cover model and pin lag
  task port_set(input logic v, input logic d);
    want_value <= v;
    want_dir <= d;
    repeat (3) @(posedge ref_clk);
  endtask : port_set
  // Check pad level and drive enable where both are settled
  task pin_chk(input logic lvl, input logic oe_b);
    @(negedge ref_clk);
    check("pin_level", pin_level, lvl);
    check("pin_oe_b", pin_oe_b, oe_b);
    @(posedge ref_clk);
  endtask : pin_chk
  // Check the registered pin value once it has settled
  task out_chk(input logic v);
    @(negedge ref_clk);
    check("pin_out", pin_out, v);
    @(posedge ref_clk);
  endtask : out_chk
  // Guard against a hang
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    check("timeout", 32'h0000_0001, 32'h0000_0000);
    test_done();
  end
  // Main sequence
  initial
  begin
    miscompares = 0;
    comparisons = 0;
    rst_b = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h0000_0000;
    timer_tick = 1'b0;
    want_value = 1'b0;
    want_dir = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    // Reset values, and an unmapped place that ignores writes
    wr(5'h14, 8'hA5);
    for (int a = 0; a <= 5'h14; a += 4)
      rdc("reset", a[4:0], 8'h00);
    pin_chk(1'b1, 1'b1);
    // State preset while the pin is an input, then override and drive
    wr(`TMWM_OFS_OUTSTATE, 8'h01);
    out_chk(1'b0);
    wr(`TMWM_OFS_CTRL, 8'h10);
    out_chk(1'b1);
    pin_chk(1'b1, 1'b1);
    port_set(1'b1, 1'b1);
    wr(`TMWM_OFS_OUTSTATE, 8'h00);
    pin_chk(1'b0, 1'b0);
    wr(`TMWM_OFS_CTRL, 8'h12);
    pin_chk(1'b0, 1'b0);
    // Force with each non-PWM action: no flag, no counter change
    wr(`TMWM_OFS_CTRL, 8'h00);
    wr(`TMWM_OFS_COUNT, 8'h40);
    for (int a = 1; a <= 3; a++)
    begin
      wr(`TMWM_OFS_OUTSTATE, {7'h00, f_init[a-1]});
      // Action first: a force applies the action already held
      wr(`TMWM_OFS_CTRL, 8'(a << 4));
      wr(`TMWM_OFS_CTRL, 8'h80 | 8'(a << 4));
      rdc("force", `TMWM_OFS_OUTSTATE, {7'h00, f_exp[a-1]});
    end
    rdc("ctrl", `TMWM_OFS_CTRL, 8'h30);
    rdc("flags", `TMWM_OFS_FLAGS, 8'h00);
    rdc("count", `TMWM_OFS_COUNT, 8'h40);
    // Normal mode wrap and overflow, action zero keeps the state
    wr(`TMWM_OFS_CTRL, 8'h00);
    wr(`TMWM_OFS_COMPARE, 8'hFF);
    wr(`TMWM_OFS_COUNT, 8'hFE);
    ticks(1);
    rdc("flags", `TMWM_OFS_FLAGS, 8'h00);
    ticks(1);
    rdc("count", `TMWM_OFS_COUNT, 8'h00);
    rdc("flags", `TMWM_OFS_FLAGS, 8'h03);
    rdc("state", `TMWM_OFS_OUTSTATE, 8'h01);
    // A counter write blocks the match at the next tick only
    wr(`TMWM_OFS_CTRL, 8'h10);
    wr(`TMWM_OFS_FLAGS, 8'h03);
    wr(`TMWM_OFS_COMPARE, 8'h05);
    wr(`TMWM_OFS_COUNT, 8'h05);
    ticks(1);
    rdc("flags", `TMWM_OFS_FLAGS, 8'h00);
    rdc("state", `TMWM_OFS_OUTSTATE, 8'h01);
    rdc("count", `TMWM_OFS_COUNT, 8'h06);
    wr(`TMWM_OFS_COUNT, 8'h03);
    ticks(3);
    rdc("count", `TMWM_OFS_COUNT, 8'h06);
    rdc("flags", `TMWM_OFS_FLAGS, 8'h02);
    rdc("state", `TMWM_OFS_OUTSTATE, 8'h00);
    wr(`TMWM_OFS_FLAGS, 8'h02);
    rdc("flags", `TMWM_OFS_FLAGS, 8'h00);
    // Clear on match with toggle
    wr(`TMWM_OFS_CTRL, 8'h12);
    wr(`TMWM_OFS_COMPARE, 8'h03);
    wr(`TMWM_OFS_COUNT, 8'h00);
    ticks(4);
    rdc("count", `TMWM_OFS_COUNT, 8'h00);
    rdc("flags", `TMWM_OFS_FLAGS, 8'h02);
    rdc("state", `TMWM_OFS_OUTSTATE, 8'h01);
    ticks(4);
    rdc("state", `TMWM_OFS_OUTSTATE, 8'h00);
    // Compare below count: run to the top and wrap
    wr(`TMWM_OFS_COUNT, 8'h10);
    wr(`TMWM_OFS_FLAGS, 8'h03);
    ticks(240);
    rdc("count", `TMWM_OFS_COUNT, 8'h00);
    rdc("flags", `TMWM_OFS_FLAGS, 8'h01);
    wr(`TMWM_OFS_COMPARE, 8'h02);
    ticks(3);
    rdc("count", `TMWM_OFS_COUNT, 8'h00);
    // Fast PWM, non-inverted
    wr(`TMWM_OFS_CTRL, 8'h23);
    wr(`TMWM_OFS_COUNT, 8'hFE);
    wr(`TMWM_OFS_FLAGS, 8'h03);
    ticks(1);
    rdc("flags", `TMWM_OFS_FLAGS, 8'h01);
    rdc("count", `TMWM_OFS_COUNT, 8'hFF);
    ticks(1);
    rdc("state", `TMWM_OFS_OUTSTATE, 8'h01);
    rdc("count", `TMWM_OFS_COUNT, 8'h00);
    ticks(3);
    rdc("state", `TMWM_OFS_OUTSTATE, 8'h00);
    rdc("flags", `TMWM_OFS_FLAGS, 8'h03);
    // Inverted; new compare waits for the top of the count
    wr(`TMWM_OFS_CTRL, 8'h33);
    wr(`TMWM_OFS_COMPARE, 8'h08);
    wr(`TMWM_OFS_COUNT, 8'h05);
    ticks(4);
    rdc("state", `TMWM_OFS_OUTSTATE, 8'h00);
    ticks(247);
    ticks(9);
    rdc("state", `TMWM_OFS_OUTSTATE, 8'h01);
    rdc("count", `TMWM_OFS_COUNT, 8'h09);
    pin_chk(1'b1, 1'b0);
    // One full period returns to the same count
    wr(`TMWM_OFS_FLAGS, 8'h03);
    ticks(256);
    rdc("count", `TMWM_OFS_COUNT, 8'h09);
    rdc("flags", `TMWM_OFS_FLAGS, 8'h03);
    // Force has no effect in fast PWM mode
    wr(`TMWM_OFS_CTRL, 8'h13);
    wr(`TMWM_OFS_CTRL, 8'h93);
    rdc("state", `TMWM_OFS_OUTSTATE, 8'h01);
    // Write with lane 0 disabled is ignored
    bus(1'b1, `TMWM_OFS_COMPARE, 8'h77, 4'h0);
    rdc("compare", `TMWM_OFS_COMPARE, 8'h08);
    // Compare zero gives a one-tick spike; action 1 toggles once a period
    wr(`TMWM_OFS_COMPARE, 8'h00);
    wr(`TMWM_OFS_CTRL, 8'h23);
    wr(`TMWM_OFS_OUTSTATE, 8'h00);
    wr(`TMWM_OFS_COUNT, 8'hFE);
    ticks(2);
    rdc("state", `TMWM_OFS_OUTSTATE, 8'h01);
    ticks(1);
    rdc("state", `TMWM_OFS_OUTSTATE, 8'h00);
    wr(`TMWM_OFS_CTRL, 8'h13);
    ticks(256);
    rdc("state", `TMWM_OFS_OUTSTATE, 8'h01);
    test_done();
  end
endmodule : tb_timer_waveform_modes

// ### verif/tmwm_port_model.sv
// Model of the general port pin and its direction bit beside the timer.
// Assumes the bench sets the wanted port level and direction on ref_clk.
module tmwm_port_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Wanted port settings from the bench
  input wire logic want_value,
  input wire logic want_dir,
  // Port register outputs toward the timer
  output logic port_value,
  output logic pin_direction_bit,
  // Timer pin drive
  input wire logic pin_out,
  input wire logic pin_oe_b,
  // Resolved pad level
  output logic pin_level
);
  // Port registers, cleared to input and low like a real port
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      port_value <= 1'b0;
      pin_direction_bit <= 1'b0;
    end
    else
    begin
      port_value <= want_value;
      pin_direction_bit <= want_dir;
    end
  end
  // Pad has a pull-up, so a released pin reads high, never the last value
  assign pin_level = pin_oe_b ? 1'b1 : pin_out;
endmodule : tmwm_port_model
